// ==== hdl/fos_cfg.svh ====
`ifndef FOS_CFG_SVH
`define FOS_CFG_SVH
// Functional notes
// RULE1 - program busy: polling bit inverts written bit
// RULE2 - status valid after 4th/6th write
// RULE3 - erase busy: polling bit zero, then data
// RULE4 - program into protected sector is ignored
// RULE5 - all-protected erase: ~100us busy, no erase
// RULE6 - each status read flips toggle bit
// RULE7 - done: stop toggling; two equal reads
// RULE8 - error bit zero ok, one on failure
// RULE9 - error on 0-to-1 program or timeout
// RULE10 - error bit sticks until reset command
// RULE11 - controller sends F0 after error
// RULE12 - controller abandons a failed sector
// RULE13 - erase time-out bit zero 120us window
// RULE14 - erase gives FF, program clears bits
// RULE15 - erase by sector or array, program bytes
// RULE16 - polling, toggle and ready/busy indications
// RULE17 - polling loop with error re-check
// RULE18 - toggle loop with error re-check
// RULE19 - controller verifies programmed byte
// RULE20 - erase status at even sector address; controller forces bit 0 low only in toggle mode
// RULE21 - erase error bit means time-out failure
// RULE22 - status reads free; bits 4,2,1,0 undefined
// RULE23 - busy array reads return status byte
// RULE24 - ready/busy low while algorithm runs

// =============================================
// timing
`define FOS_CLK_NS      20
`define FOS_PBUSY_NS    100000
`define FOS_ETMO_NS     120000
`define FOS_PBUSY_CYC   (`FOS_PBUSY_NS / `FOS_CLK_NS)
`define FOS_ETMO_CYC    (`FOS_ETMO_NS / `FOS_CLK_NS)
`define FOS_PROG_CYC    16
`define FOS_ERASE_CYC   64
// =============================================
// command cycles
`define FOS_CMD_UNL1    8'hAA
`define FOS_CMD_UNL2    8'h55
`define FOS_CMD_PROG    8'hA0
`define FOS_CMD_ERASE   8'h80
`define FOS_CMD_SECT    8'h30
`define FOS_CMD_BULK    8'h10
`define FOS_CMD_RESET   8'hF0
`define FOS_ADR_UNL1    12'h555
`define FOS_ADR_UNL2    12'hAAA
// =============================================
// status byte bit positions
`define FOS_ST_POLL     7
`define FOS_ST_TOG      6
`define FOS_ST_ERR      5
`define FOS_ST_ETMO     3
`define FOS_RST_BYTE    8'h00
// =============================================
// controller register map
`define FOS_REG_CTRL    8'h00
`define FOS_REG_ADDR    8'h04
`define FOS_REG_DATA    8'h08
`define FOS_REG_STAT    8'h0C
`define FOS_CTRL_MODE   3
`define FOS_ADDR_SEL    16
`define FOS_STAT_BUSY   0
`define FOS_STAT_ERR    1
`define FOS_STAT_DONE   2
`define FOS_STAT_RDATA  8
`endif

// ==== hdl/fos_pkg.sv ====
package fos_pkg;
    typedef enum logic [3:0] {
        S_READ, S_UNL1, S_UNL2, S_PCMD, S_ECMD, S_EUNL1, S_EUNL2,
        S_ETMO, S_PROG, S_ERASE, S_PBUSY, S_ERR
    } fos_dstate_type;

    typedef enum logic [2:0] {
        OP_READ, OP_PROG, OP_SERASE, OP_BERASE, OP_RESET
    } fos_op_type;

    typedef enum logic [2:0] {
        H_IDLE, H_WR, H_GAP, H_RD, H_WAIT
    } fos_hstate_type;

    typedef struct packed {
        fos_dstate_type st;
        logic [15:0]    cnt;
        logic [15:0]    pa;
        logic [7:0]     pd;
        logic           eop;
        logic           perr;
        logic           tog;
        logic           err;
        logic [11:0]    esel;
        logic           arr;
        logic [7:0]     dout;
        logic           doe;
        logic           rdy;
        logic           mwr;
        logic           mer;
    } fos_dev_type;

    typedef struct packed {
        fos_hstate_type st;
        logic           av;
        logic           aw;
        logic [7:0]     aa;
        logic [31:0]    hrdata;
        logic           hready;
        logic           hresp;
        fos_op_type     op;
        logic           mode;
        logic [27:0]    adr;
        logic [7:0]     dat;
        logic [2:0]     step;
        logic           first;
        logic           chk;
        logic           vfy;
        logic           fail;
        logic [7:0]     prev;
        logic [7:0]     rdata;
        logic           busy;
        logic           err;
        logic           done;
        logic [15:0]    a;
        logic [7:0]     d;
        logic           doe;
        logic           wr;
        logic           rd;
        logic [11:0]    sel;
    } fos_host_type;
endpackage : fos_pkg

// ==== hdl/fos_if.sv ====
`timescale 1ns/1ns
interface fos_if;
    logic [15:0] addr;
    logic [7:0]  host_d;
    logic        host_doe;
    logic [7:0]  dev_d;
    logic        dev_doe;
    logic [7:0]  data;
    logic        wr;
    logic        rd;
    logic [7:0]  msel;
    logic [3:0]  ssel;
    logic        ready;

    // undriven data bus floats high through the board pull-ups
    assign data = dev_doe ? dev_d : (host_doe ? host_d : 8'hFF);

    modport dev (input addr, data, wr, rd, msel, ssel,
                 output dev_d, dev_doe, ready);
    modport host (output addr, host_d, host_doe, wr, rd, msel, ssel,
                  input data, dev_doe, ready);
endinterface : fos_if

// ==== hdl/fos_device.sv ====
`timescale 1ns/1ns
`include "fos_cfg.svh"
module fos_device #(
    parameter int SAW       = 4,
    parameter int PROG_CYC  = `FOS_PROG_CYC,
    parameter int ERASE_CYC = `FOS_ERASE_CYC,
    parameter int PBUSY_CYC = `FOS_PBUSY_CYC,
    parameter int ETMO_CYC  = `FOS_ETMO_CYC
) (
    fos_if.dev         BUS,
    input  wire logic  CLOCK,
    input  wire logic  RST,
    input  wire logic [7:0] MAIN_PROT,
    input  wire logic [3:0] BOOT_PROT,
    input  wire logic  ALG_FAIL
);
    localparam int NB = 12 << SAW;

    fos_pkg::fos_dev_type s_q;
    fos_pkg::fos_dev_type s_d;
    logic [7:0]  mem [0:NB-1];
    logic [3:0]  wsec;
    logic [SAW+3:0] idx;
    logic [SAW+3:0] pidx;
    logic        sel_any;
    logic        cur_arr;
    logic        hit;
    logic        rhit;
    logic [7:0]  cmd;
    logic [11:0] a12;
    logic [11:0] prot;
    logic [7:0]  stat;
    logic        algo;
    logic        er_go;
    logic [11:0] er_set;

    // =============================================
    // sector decode
    function automatic logic [3:0] sec_of(input logic [7:0] m,
                                          input logic [3:0] b);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 3; i >= 0; i--) begin
            if (b[i]) r = 4'(8 + i);
        end
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) r = 4'(i);
        end
        return r;
    endfunction : sec_of

    assign wsec    = sec_of(BUS.msel, BUS.ssel);
    assign sel_any = (|BUS.msel) | (|BUS.ssel);
    assign cur_arr = ~(|BUS.msel);
    assign idx     = {wsec, BUS.addr[SAW-1:0]};
    assign pidx    = s_q.pa[SAW+3:0];
    assign prot    = {BOOT_PROT, MAIN_PROT};
    assign hit     = BUS.wr & sel_any;
    assign rhit    = BUS.rd & sel_any;
    assign cmd     = BUS.data;
    assign a12     = BUS.addr[11:0];

    // =============================================
    // status byte
    always_comb begin
        stat = `FOS_RST_BYTE; // [RULE22]
        // erase holds zero, program shows the inverted bit
        stat[`FOS_ST_POLL] = s_q.eop ? 1'b0 : ~s_q.pd[7]; // [RULE1] [RULE3]
        stat[`FOS_ST_TOG]  = s_q.tog; // [RULE16]
        stat[`FOS_ST_ERR]  = s_q.err; // [RULE8] [RULE21]
        stat[`FOS_ST_ETMO] = (s_q.st != fos_pkg::S_ETMO); // [RULE13]
    end

    assign algo = s_q.st inside {fos_pkg::S_ETMO, fos_pkg::S_PROG,
                                 fos_pkg::S_ERASE, fos_pkg::S_PBUSY,
                                 fos_pkg::S_ERR};

    // =============================================
    // sequencer
    always_comb begin
        s_d    = s_q;
        s_d.doe = 1'b0;
        s_d.mwr = 1'b0;
        s_d.mer = 1'b0;
        er_go  = 1'b0;
        er_set = s_q.esel;
        case (s_q.st)
            fos_pkg::S_READ: begin
                if (hit && cmd == `FOS_CMD_UNL1 && a12 == `FOS_ADR_UNL1)
                    s_d.st = fos_pkg::S_UNL1;
            end
            fos_pkg::S_UNL1: begin
                if (hit) begin
                    s_d.st = (cmd == `FOS_CMD_UNL2 &&
                              a12 == `FOS_ADR_UNL2) ?
                             fos_pkg::S_UNL2 : fos_pkg::S_READ;
                end
            end
            fos_pkg::S_UNL2: begin
                if (hit) begin
                    s_d.st = fos_pkg::S_READ;
                    if (a12 == `FOS_ADR_UNL1 && cmd == `FOS_CMD_PROG)
                        s_d.st = fos_pkg::S_PCMD;
                    if (a12 == `FOS_ADR_UNL1 && cmd == `FOS_CMD_ERASE)
                        s_d.st = fos_pkg::S_ECMD;
                end
            end
            fos_pkg::S_PCMD: begin
                if (hit) begin
                    s_d.pa  = 16'({wsec, BUS.addr[SAW-1:0]});
                    s_d.pd  = cmd;
                    s_d.arr = cur_arr;
                    s_d.eop = 1'b0;
                    // programming can only clear bits
                    s_d.perr = |(cmd & ~mem[idx]); // [RULE9] [RULE14]
                    s_d.cnt = 16'(PROG_CYC);
                    // fourth write starts the algorithm
                    s_d.st = prot[wsec] ? fos_pkg::S_READ : // [RULE4]
                             fos_pkg::S_PROG; // [RULE2] [RULE15]
                end
            end
            fos_pkg::S_ECMD: begin
                if (hit) begin
                    s_d.st = (cmd == `FOS_CMD_UNL1 &&
                              a12 == `FOS_ADR_UNL1) ?
                             fos_pkg::S_EUNL1 : fos_pkg::S_READ;
                end
            end
            fos_pkg::S_EUNL1: begin
                if (hit) begin
                    s_d.st = (cmd == `FOS_CMD_UNL2 &&
                              a12 == `FOS_ADR_UNL2) ?
                             fos_pkg::S_EUNL2 : fos_pkg::S_READ;
                end
            end
            fos_pkg::S_EUNL2: begin
                if (hit) begin
                    s_d.st  = fos_pkg::S_READ;
                    s_d.arr = cur_arr;
                    s_d.eop = 1'b1;
                    if (cmd == `FOS_CMD_SECT) begin
                        // sixth write opens the time-out window
                        s_d.esel = 12'(1) << wsec; // [RULE2]
                        s_d.cnt  = 16'(ETMO_CYC); // [RULE13]
                        s_d.st   = fos_pkg::S_ETMO;
                    end else if (cmd == `FOS_CMD_BULK &&
                                 a12 == `FOS_ADR_UNL1) begin
                        er_set = cur_arr ? 12'hF00 : 12'h0FF; // [RULE15]
                        er_go  = 1'b1;
                    end
                end
            end
            fos_pkg::S_ETMO: begin
                s_d.cnt = s_q.cnt - 16'(1);
                if (hit && cmd == `FOS_CMD_SECT) begin
                    s_d.esel = s_q.esel | (12'(1) << wsec);
                    s_d.cnt  = 16'(ETMO_CYC); // [RULE13]
                end else if (hit) begin
                    s_d.st = fos_pkg::S_READ;
                end else if (s_q.cnt == 16'(0)) begin
                    er_go = 1'b1;
                end
            end
            fos_pkg::S_PROG: begin
                s_d.cnt = s_q.cnt - 16'(1);
                if (s_q.cnt == 16'(0)) begin
                    s_d.mwr = 1'b1;
                    if (s_q.perr || ALG_FAIL) begin
                        s_d.err = 1'b1; // [RULE8] [RULE9]
                        s_d.st  = fos_pkg::S_ERR;
                    end else begin
                        s_d.st = fos_pkg::S_READ; // [RULE7]
                    end
                end
            end
            fos_pkg::S_ERASE: begin
                s_d.cnt = s_q.cnt - 16'(1);
                if (s_q.cnt == 16'(0)) begin
                    s_d.mer = 1'b1;
                    if (ALG_FAIL) begin
                        s_d.err = 1'b1; // [RULE21]
                        s_d.st  = fos_pkg::S_ERR;
                    end else begin
                        s_d.st = fos_pkg::S_READ; // [RULE7]
                    end
                end
            end
            fos_pkg::S_PBUSY: begin
                s_d.cnt = s_q.cnt - 16'(1);
                if (s_q.cnt == 16'(0))
                    s_d.st = fos_pkg::S_READ;
            end
            fos_pkg::S_ERR: begin
                // only the reset command below leaves this state
                s_d.st = fos_pkg::S_ERR; // [RULE10]
            end
            default: s_d.st = fos_pkg::S_READ;
        endcase

        if (er_go) begin
            s_d.esel = er_set & ~prot;
            if ((er_set & ~prot) == 12'h000) begin
                s_d.cnt = 16'(PBUSY_CYC); // [RULE5]
                s_d.st  = fos_pkg::S_PBUSY;
            end else begin
                s_d.cnt = 16'(ERASE_CYC);
                s_d.st  = fos_pkg::S_ERASE;
            end
        end

        // the algorithm itself runs to the end; reset acts elsewhere
        if (hit && cmd == `FOS_CMD_RESET &&
            !(s_q.st inside {fos_pkg::S_PROG, fos_pkg::S_ERASE,
                             fos_pkg::S_PBUSY})) begin
            s_d.st  = fos_pkg::S_READ; // [RULE11]
            s_d.err = 1'b0; // [RULE10]
        end

        if (rhit) begin
            s_d.doe = 1'b1;
            // cells land one cycle after the algorithm ends; hide them
            if ((algo || s_q.mwr || s_q.mer) && cur_arr == s_q.arr) begin
                s_d.dout = stat; // [RULE23]
                s_d.tog  = ~s_q.tog; // [RULE6]
            end else begin
                s_d.dout = mem[idx]; // [RULE7]
            end
        end

        s_d.rdy = !(s_d.st inside {fos_pkg::S_ETMO, fos_pkg::S_PROG,
                                   fos_pkg::S_ERASE, fos_pkg::S_PBUSY} ||
                    s_d.mwr || s_d.mer); // [RULE24]
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            s_q      <= '0;
            s_q.st   <= fos_pkg::S_READ;
            s_q.rdy  <= 1'b1;
            s_q.eop  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // =============================================
    // cell array; contents are undefined until erased
    always_ff @(posedge CLOCK) begin
        if (s_q.mwr)
            mem[pidx] <= mem[pidx] & s_q.pd; // [RULE14]
        if (s_q.mer) begin
            for (int i = 0; i < NB; i++) begin
                if (s_q.esel[i >> SAW])
                    mem[i] <= 8'hFF; // [RULE14] [RULE15]
            end
        end
    end

    assign BUS.dev_d   = s_q.dout;
    assign BUS.dev_doe = s_q.doe;
    assign BUS.ready   = s_q.rdy; // [RULE16]
endmodule : fos_device

// ==== hdl/fos_host.sv ====
`timescale 1ns/1ns
`include "fos_cfg.svh"
module fos_host (
    fos_if.host        BUS,
    input  wire logic  CLOCK,
    input  wire logic  RST,
    input  wire logic  HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic  HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic  HREADY,
    output logic [31:0] HRDATA,
    output logic       HREADYOUT,
    output logic       HRESP
);
    fos_pkg::fos_host_type s_q;
    fos_pkg::fos_host_type s_d;
    logic [23:0] stp;
    logic [2:0]  nstep;
    logic        stop;
    logic        tgt;
    logic [31:0] rv;

    function automatic logic [23:0] step_of(input fos_pkg::fos_op_type o,
        input logic [2:0] k, input logic [15:0] pa, input logic [7:0] pd);
        logic [23:0] r;
        r = {16'h0555, `FOS_CMD_UNL1};
        if (o == fos_pkg::OP_RESET) r = {pa, `FOS_CMD_RESET};
        else if (k == 3'd1 || k == 3'd4) r = {16'h0AAA, `FOS_CMD_UNL2};
        else if (k == 3'd2)
            r = {16'h0555, (o == fos_pkg::OP_PROG) ? `FOS_CMD_PROG :
                           `FOS_CMD_ERASE};
        else if (k == 3'd3 && o == fos_pkg::OP_PROG) r = {pa, pd};
        else if (k == 3'd5 && o == fos_pkg::OP_SERASE)
            r = {pa, `FOS_CMD_SECT};
        else if (k == 3'd5) r = {16'h0555, `FOS_CMD_BULK};
        return r;
    endfunction : step_of

    assign stp   = step_of(s_q.op, s_q.step, s_q.adr[15:0], s_q.dat);
    assign nstep = (s_q.op == fos_pkg::OP_PROG) ? 3'd4 :
                   (s_q.op == fos_pkg::OP_RESET) ? 3'd1 :
                   (s_q.op == fos_pkg::OP_READ) ? 3'd0 : 3'd6;
    assign tgt   = (s_q.op == fos_pkg::OP_PROG) ? s_q.dat[7] : 1'b1;
    // polling compares against the written bit, or one for erase, toggle against last read
    assign stop  = s_q.mode ? (BUS.data[7] == tgt) : // [RULE17]
                   (BUS.data[6] == s_q.prev[6]); // [RULE18] [RULE7]

    always_comb begin
        rv = 32'h0000_0000;
        case (HADDR[7:0])
            `FOS_REG_CTRL: rv = {28'h0, s_q.mode, s_q.op};
            `FOS_REG_ADDR: rv = {4'h0, s_q.adr};
            `FOS_REG_DATA: rv = {24'h0, s_q.dat};
            `FOS_REG_STAT: rv = {16'h0, s_q.rdata, 5'h00, s_q.done,
                                 s_q.err, s_q.busy};
            default:       rv = 32'h0000_0000;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.wr  = 1'b0;
        s_d.rd  = 1'b0;
        s_d.doe = 1'b0;
        s_d.hready = 1'b1;
        s_d.hresp  = 1'b0;
        if (HREADY) begin
            s_d.av = HSEL & HTRANS[1];
            s_d.aw = HWRITE;
            s_d.aa = HADDR[7:0];
            if (HSEL && HTRANS[1] && !HWRITE) s_d.hrdata = rv;
        end
        if (s_q.av && s_q.aw) begin
            case (s_q.aa)
                `FOS_REG_ADDR: s_d.adr = HWDATA[27:0];
                `FOS_REG_DATA: s_d.dat = HWDATA[7:0];
                `FOS_REG_CTRL: begin
                    if (!s_q.busy) begin
                        s_d.op   = fos_pkg::fos_op_type'(HWDATA[2:0]);
                        s_d.mode = HWDATA[`FOS_CTRL_MODE];
                        s_d.busy = 1'b1;
                        s_d.done = 1'b0;
                        s_d.err  = 1'b0;
                        s_d.step = 3'd0;
                        s_d.first = 1'b1;
                        s_d.chk  = 1'b0;
                        s_d.vfy  = 1'b0;
                        s_d.fail = 1'b0;
                        s_d.sel  = s_q.adr[27:16];
                        s_d.st   = (HWDATA[2:0] == 3'd0) ?
                                   fos_pkg::H_RD : fos_pkg::H_WR;
                    end
                end
                default: ;
            endcase
        end

        case (s_q.st)
            fos_pkg::H_IDLE: begin
                // a start written this cycle keeps its selects
                if (s_d.st == fos_pkg::H_IDLE) s_d.sel = 12'h000;
            end
            fos_pkg::H_WR: begin
                s_d.a   = stp[23:8];
                s_d.d   = stp[7:0];
                s_d.wr  = 1'b1;
                s_d.doe = 1'b1;
                s_d.step = s_q.step + 3'd1;
                s_d.st  = fos_pkg::H_GAP;
            end
            fos_pkg::H_GAP: begin
                s_d.st = (s_q.step < nstep) ? fos_pkg::H_WR :
                         fos_pkg::H_RD; // [RULE2]
                if (s_q.op == fos_pkg::OP_RESET && s_q.step == nstep) begin
                    s_d.st   = fos_pkg::H_IDLE;
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                end
            end
            fos_pkg::H_RD: begin
                s_d.a = s_q.adr[15:0];
                if (!s_q.mode && s_q.op inside {fos_pkg::OP_SERASE,
                                                fos_pkg::OP_BERASE})
                    s_d.a[0] = 1'b0; // [RULE20]
                s_d.rd = 1'b1;
                s_d.st = fos_pkg::H_WAIT;
            end
            fos_pkg::H_WAIT: begin
                if (BUS.dev_doe) begin
                    s_d.prev  = BUS.data;
                    s_d.rdata = BUS.data;
                    s_d.first = 1'b0;
                    s_d.st    = fos_pkg::H_RD;
                    if (s_q.op == fos_pkg::OP_READ) begin
                        s_d.fail = 1'b0;
                    end else if (s_q.vfy) begin
                        s_d.fail = (BUS.data != s_q.dat); // [RULE19]
                        s_d.vfy  = 1'b0;
                    end else if (!s_q.first && stop) begin
                        s_d.vfy = (s_q.op == fos_pkg::OP_PROG); // [RULE19]
                    end else if (!s_q.first && s_q.chk) begin
                        s_d.fail = 1'b1; // [RULE17] [RULE18]
                    end else if (BUS.data[5]) begin
                        s_d.chk = 1'b1; // [RULE17] [RULE18]
                    end
                    if (s_d.fail) begin
                        // failed sector is left to software
                        s_d.err  = 1'b1; // [RULE12]
                        s_d.op   = fos_pkg::OP_RESET; // [RULE11]
                        s_d.step = 3'd0;
                        s_d.st   = fos_pkg::H_WR;
                    end else if (s_q.op == fos_pkg::OP_READ ||
                                 (!s_q.vfy && !(!s_q.first && stop) &&
                                  1'b0) || (s_q.vfy) ||
                                 (!s_q.first && stop &&
                                  s_q.op != fos_pkg::OP_PROG)) begin
                        s_d.st   = fos_pkg::H_IDLE;
                        s_d.busy = 1'b0;
                        s_d.done = 1'b1;
                    end
                end
            end
            default: s_d.st = fos_pkg::H_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            s_q        <= '0;
            s_q.st     <= fos_pkg::H_IDLE;
            s_q.hready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign HRDATA    = s_q.hrdata;
    assign HREADYOUT = s_q.hready;
    assign HRESP     = s_q.hresp;
    assign BUS.addr     = s_q.a;
    assign BUS.host_d   = s_q.d;
    assign BUS.host_doe = s_q.doe;
    assign BUS.wr       = s_q.wr;
    assign BUS.rd       = s_q.rd;
    assign BUS.msel     = s_q.sel[7:0];
    assign BUS.ssel     = s_q.sel[11:8];
endmodule : fos_host

// ==== tb/fos_assertions.sv ====
`timescale 1ns/1ns
// ====================
// flash link checks
module fos_assertions (
    input wire logic       CLOCK,
    input wire logic       RST,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] msel,
    input wire logic [3:0] ssel,
    input wire logic       ready,
    input wire logic [7:0] dev_d,
    input wire logic       dev_doe,
    input wire logic       host_doe
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    logic t_q;
    logic b_q;
    // toggle bit of the last answer, and whether it came while busy
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            t_q <= 1'b0;
            b_q <= 1'b0;
        end else if (dev_doe) begin
            t_q <= dev_d[6];
            b_q <= !ready;
        end
    end
    read_answer_a: assert property (
        rd && (|{msel, ssel}) |=> dev_doe) else $error("read unanswered");
    answer_once_a: assert property (
        dev_doe |=> !dev_doe) else $error("answer held too long");
    answer_cause_a: assert property (
        dev_doe |-> $past(rd)) else $error("answer without read");
    bus_clash_a: assert property (
        !(dev_doe && host_doe)) else $error("both drive data");
    busy_min_a: assert property (
        $fell(ready) |-> !ready [*5]) else $error("busy too short");
    busy_max_a: assert property (
        $fell(ready) |-> ##[1:200] ready) else $error("busy too long");
    toggle_flip_a: assert property (
        dev_doe && !ready && b_q |-> dev_d[6] != t_q)
        else $error("toggle bit stuck");
    busy_quiet_a: assert property (
        !ready |-> !wr) else $error("write while busy");
    select_held_a: assert property (
        wr || rd |-> (|{msel, ssel})) else $error("access unselected");
    cover property ($fell(ready));
    cover property (dev_doe && !ready && b_q);
    cover property ($rose(ready));
endmodule : fos_assertions

// ==== tb/tb.sv ====
`timescale 1ns/1ns
// ====================
// bench
module tb;
    logic        CLOCK = 1'b0;
    logic        RST = 1'b1;
    logic [31:0] HADDR = 32'h0;
    logic [1:0]  HTRANS = 2'h0;
    logic        HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic [31:0] HRDATA;
    logic        HREADYOUT;
    logic [7:0]  prot = 8'h00;
    logic [3:0]  bprot = 4'h0;
    logic        hsel = 1'b1;
    logic        fail = 1'b0;
    logic [31:0] r;
    int          mismatches = 0;
    int          n_tests = 0;
    fos_if bus ();
    always #10 CLOCK = ~CLOCK;
    fos_device #(.PROG_CYC(4), .ERASE_CYC(8), .PBUSY_CYC(40),
        .ETMO_CYC(50)) fos_device_inst (.BUS(bus), .CLOCK(CLOCK),
        .RST(RST), .MAIN_PROT(prot), .BOOT_PROT(bprot), .ALG_FAIL(fail));
    fos_host fos_host_inst (.BUS(bus), .CLOCK(CLOCK), .RST(RST),
        .HSEL(hsel), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP());
    fos_assertions fos_assertions_inst (.CLOCK(CLOCK), .RST(RST),
        .wr(bus.wr), .rd(bus.rd), .msel(bus.msel), .ssel(bus.ssel),
        .ready(bus.ready), .dev_d(bus.dev_d), .dev_doe(bus.dev_doe),
        .host_doe(bus.host_doe));
    task tally_and_finish;
        if (mismatches == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task cmp(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task hw;
        int i;
        i = 0;
        do begin
            @(posedge CLOCK);
            i++;
        end while (HREADYOUT !== 1'b1 && i < 50);
        if (HREADYOUT !== 1'b1) begin
            mismatches++;
            tally_and_finish();
        end
    endtask : hw
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        HADDR <= {24'h000000, a};
        HWRITE <= w;
        HTRANS <= 2'h2;
        hw();
        HTRANS <= 2'h0;
        HWDATA <= d;
        hw();
        r = HRDATA;
    endtask : ahb
    // loads address, data and command, then polls busy in the status word
    task run(input logic [3:0] c, input logic [27:0] a, input logic [7:0] d);
        int i;
        ahb(1'b1, 8'h04, {4'h0, a});
        ahb(1'b1, 8'h08, {24'h000000, d});
        ahb(1'b1, 8'h00, {28'h0000000, c});
        repeat (2) @(posedge CLOCK);
        i = 0;
        do begin
            ahb(1'b0, 8'h0C, 32'h0);
            i++;
        end while (r[0] !== 1'b0 && i < 300);
        if (r[0] !== 1'b0) begin
            mismatches++;
            tally_and_finish();
        end
    endtask : run
    initial begin
        repeat (12) @(posedge CLOCK);
        RST <= 1'b0;
        run(4'h3, 28'h0010000, 8'h00);
        cmp({r[1], r[15:8]}, 9'h0FF);
        run(4'h9, 28'h0010003, 8'h5A);
        cmp({r[1], r[15:8]}, 9'h05A);
        run(4'h1, 28'h0010004, 8'hA5);
        cmp({r[1], r[15:8]}, 9'h0A5);
        run(4'h1, 28'h0010003, 8'hFF);
        cmp({r[1], 8'h00}, 9'h100);
        run(4'h0, 28'h0010003, 8'h00);
        cmp({1'b0, r[15:8]}, 9'h05A);
        prot <= 8'h01;
        run(4'hA, 28'h0010000, 8'h00);
        run(4'h0, 28'h0010003, 8'h00);
        cmp({1'b0, r[15:8]}, 9'h05A);
        prot <= 8'h02;
        run(4'h1, 28'h0020013, 8'h00);
        run(4'h0, 28'h0020013, 8'h00);
        cmp({1'b0, r[15:8]}, 9'h0FF);
        prot <= 8'h00;
        run(4'h2, 28'h0010000, 8'h00);
        run(4'h0, 28'h0010004, 8'h00);
        cmp({1'b0, r[15:8]}, 9'h0FF);
        fail <= 1'b1;
        run(4'hA, 28'h0010000, 8'h00);
        cmp({r[1], 8'h00}, 9'h100);
        tally_and_finish();
    end
endmodule : tb
